// ==== core/instruction_exec_subset.sv ====
// Operation
// - option load copies accumulator to prescaler config; flags untouched
// - return-with-literal puts the 8-bit literal in accumulator; flags untouched
// - return-with-literal reloads program counter from stack top entry
// - return-with-literal takes two cycles; second refetches from return address
// - sleep clears watchdog counter and its prescaler
// - sleep sets the timeout flag
// - sleep clears powerdown flag; pin-change wakeup flag keeps its value
// - after sleep, execution halts and oscillator stops
// - rotate left through carry; only carry changes
// - rotate right through carry; only carry changes
// - subtract computes file minus accumulator; updates carry, half carry, zero
// - destination bit 0 writes accumulator, 1 writes the file register
// - file operand is a 5-bit address plus one destination bit
`timescale 1ns/1ns
module instruction_exec_subset #(
  parameter int PC_W       = 10,
  parameter int WDOG_PRE_W = exec_subset_pkg::WDOG_PRE_W,
  parameter int WDOG_CNT_W = exec_subset_pkg::WDOG_CNT_W
) (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_arst_n,
  input  wire logic                 i_instr_valid,
  input  wire logic [11:0]          i_instr,
  output logic                      o_instr_ready,
  input  wire logic [PC_W-1:0]      i_stack_top,
  output logic                      o_pc_load,
  output logic [PC_W-1:0]           o_pc_value,
  output logic                      o_refetch,
  output logic [7:0]                o_option,
  output logic                      o_osc_stop,
  input  wire logic                 i_wake_pin,
  input  wire logic [7:0]           i_addr,
  input  wire logic [31:0]          i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic [31:0]               o_rdata,
  output logic                      o_irq
);

  // ****************************************************************
  // decode
  // ****************************************************************
  function automatic exec_subset_pkg::op_t decode(input logic [11:0] instr);
    exec_subset_pkg::op_t op;
    op = exec_subset_pkg::OP_UNKNOWN;
    if (instr == exec_subset_pkg::OPC_OPTION) begin
      op = exec_subset_pkg::OP_OPTION;
    end else if (instr == exec_subset_pkg::OPC_SLEEP) begin
      op = exec_subset_pkg::OP_SLEEP;
    end else if ((instr & exec_subset_pkg::MSK_LIT) == exec_subset_pkg::OPC_RET_LIT) begin
      op = exec_subset_pkg::OP_RET_LIT;
    end else if ((instr & exec_subset_pkg::MSK_FILE_OP) == exec_subset_pkg::OPC_SUB_FILE) begin
      op = exec_subset_pkg::OP_SUB;
    end else if ((instr & exec_subset_pkg::MSK_FILE_OP) == exec_subset_pkg::OPC_ROT_LEFT) begin
      op = exec_subset_pkg::OP_ROT_L;
    end else if ((instr & exec_subset_pkg::MSK_FILE_OP) == exec_subset_pkg::OPC_ROT_RIGHT) begin
      op = exec_subset_pkg::OP_ROT_R;
    end
    return op;
  endfunction : decode

  // bus address to file-register index, valid flag in msb
  function automatic logic [5:0] file_index(input logic [7:0] addr);
    logic hit;
    hit = (addr[7] == exec_subset_pkg::FILE_BASE[7]) && (addr[1:0] == 2'b00);
    return {hit, addr[6:2]};
  endfunction : file_index

  typedef enum logic [1:0] {ST_RUN, ST_REFETCH, ST_SLEEP} state_t;

  // ****************************************************************
  // state
  // ****************************************************************
  state_t                          state_q, state_d;
  logic [7:0]                      acc_q, acc_d;
  logic [7:0]                      option_q, option_d;
  exec_subset_pkg::alu_flags_t     flags_q, flags_d;
  logic                            to_q, to_d;
  logic                            pdown_q, pdown_d;
  logic                            wuf_q, wuf_d;
  logic [7:0]                      file_q [exec_subset_pkg::FILE_DEPTH];
  logic [7:0]                      file_d [exec_subset_pkg::FILE_DEPTH];
  logic [WDOG_PRE_W-1:0]           wpre_q, wpre_d;
  logic [WDOG_CNT_W-1:0]           wcnt_q, wcnt_d;
  logic [exec_subset_pkg::IRQ_W-1:0] ist_q, ist_d;
  logic [exec_subset_pkg::IRQ_W-1:0] imask_q, imask_d;
  logic [PC_W-1:0]                 pc_q, pc_d;
  logic                            pc_load_q, pc_load_d;
  logic [31:0]                     rdata_q, rdata_d;
  logic                            wake_s1_q, wake_s2_q, wake_s3_q;

  exec_subset_pkg::op_t            op;
  exec_subset_pkg::alu_res_t       alu;
  logic [4:0]                      faddr;
  logic                            dest_file;
  logic                            take;
  logic [exec_subset_pkg::IRQ_W-1:0] ev;
  logic [5:0]                      bus_fidx;
  logic                            pin_wake;

  // ****************************************************************
  // instruction issue and datapath
  // ****************************************************************
  assign o_instr_ready = (state_q == ST_RUN);
  assign take          = i_instr_valid && o_instr_ready;
  assign op            = take ? decode(i_instr) : exec_subset_pkg::OP_NONE;
  assign faddr         = i_instr[exec_subset_pkg::FILE_ADDR_W-1:0];
  assign dest_file     = i_instr[exec_subset_pkg::DEST_BIT];
  assign bus_fidx      = file_index(i_addr);
  assign pin_wake      = wake_s2_q && !wake_s3_q;

  exec_alu u_alu (
    .i_op    (op),
    .i_file  (file_q[faddr]),
    .i_acc   (acc_q),
    .i_carry (flags_q.carry),
    .o_res   (alu)
  );

  // execution, sleep, watchdog and register writes
  always_comb begin
    state_d   = state_q;
    acc_d     = acc_q;
    option_d  = option_q;
    flags_d   = flags_q;
    to_d      = to_q;
    pdown_d   = pdown_q;
    wuf_d     = wuf_q;
    file_d    = file_q;
    pc_d      = pc_q;
    pc_load_d = 1'b0;
    imask_d   = imask_q;
    ev        = '0;
    // free-running watchdog: prescaler wrap advances the counter
    wpre_d    = wpre_q + 1'b1;
    wcnt_d    = (wpre_q == '1) ? wcnt_q + 1'b1 : wcnt_q;

    // software writes first, so instruction results take priority
    if (i_wr) begin
      if (bus_fidx[5]) begin
        file_d[bus_fidx[4:0]] = i_wdata[7:0];
      end
      case (i_addr)
        exec_subset_pkg::REG_ACC:      acc_d    = i_wdata[7:0];
        exec_subset_pkg::REG_OPTION:   option_d = i_wdata[7:0];
        exec_subset_pkg::REG_IRQ_MASK: imask_d  = i_wdata[exec_subset_pkg::IRQ_W-1:0];
        exec_subset_pkg::REG_FLAGS: begin
          flags_d.carry = i_wdata[exec_subset_pkg::FLG_CARRY];
          flags_d.half  = i_wdata[exec_subset_pkg::FLG_HALF];
          flags_d.zero  = i_wdata[exec_subset_pkg::FLG_ZERO];
          // wakeup flag is write-one-to-clear
          if (i_wdata[exec_subset_pkg::FLG_WUF]) begin
            wuf_d = 1'b0;
          end
        end
        default: ;
      endcase
    end

    case (state_q)
      ST_RUN: begin
        case (op)
          exec_subset_pkg::OP_OPTION: begin
            option_d                      = acc_q;
            ev[exec_subset_pkg::EV_OPTION] = 1'b1;
          end
          exec_subset_pkg::OP_RET_LIT: begin
            acc_d     = i_instr[7:0];
            pc_d      = i_stack_top;
            pc_load_d = 1'b1;
            state_d   = ST_REFETCH;
            ev[exec_subset_pkg::EV_RETURN] = 1'b1;
          end
          exec_subset_pkg::OP_SLEEP: begin
            wpre_d  = '0;
            wcnt_d  = '0;
            to_d    = 1'b1;
            pdown_d = 1'b0;
            state_d = ST_SLEEP;
            ev[exec_subset_pkg::EV_SLEEP] = 1'b1;
          end
          exec_subset_pkg::OP_SUB,
          exec_subset_pkg::OP_ROT_L,
          exec_subset_pkg::OP_ROT_R: begin
            if (dest_file) begin
              file_d[faddr] = alu.result;
            end else begin
              acc_d = alu.result;
            end
            if (alu.wr_carry) flags_d.carry = alu.flags.carry;
            if (alu.wr_half)  flags_d.half  = alu.flags.half;
            if (alu.wr_zero)  flags_d.zero  = alu.flags.zero;
          end
          exec_subset_pkg::OP_UNKNOWN: begin
            ev[exec_subset_pkg::EV_UNKNOWN] = 1'b1;
          end
          default: ;
        endcase
      end
      ST_REFETCH: begin
        // second cycle: fetch unit refetches from the restored address
        state_d = ST_RUN;
      end
      ST_SLEEP: begin
        // halted; only a pin edge or software wake resumes
        if (pin_wake) begin
          wuf_d   = 1'b1;
          state_d = ST_RUN;
          ev[exec_subset_pkg::EV_WAKE] = 1'b1;
        end else if (i_wr && (i_addr == exec_subset_pkg::REG_CTRL)
                     && i_wdata[exec_subset_pkg::CTRL_WAKE_BIT]) begin
          state_d = ST_RUN;
          ev[exec_subset_pkg::EV_WAKE] = 1'b1;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q   <= ST_RUN;
      acc_q     <= 8'h00;
      option_q  <= exec_subset_pkg::OPTION_RST;
      flags_q   <= '0;
      to_q      <= exec_subset_pkg::TO_RST;
      pdown_q   <= exec_subset_pkg::PDOWN_RST;
      wuf_q     <= 1'b0;
      wpre_q    <= '0;
      wcnt_q    <= '0;
      imask_q   <= '0;
      pc_q      <= '0;
      pc_load_q <= 1'b0;
      for (int i = 0; i < exec_subset_pkg::FILE_DEPTH; i++) begin
        file_q[i] <= 8'h00;
      end
    end else begin
      state_q   <= state_d;
      acc_q     <= acc_d;
      option_q  <= option_d;
      flags_q   <= flags_d;
      to_q      <= to_d;
      pdown_q   <= pdown_d;
      wuf_q     <= wuf_d;
      wpre_q    <= wpre_d;
      wcnt_q    <= wcnt_d;
      imask_q   <= imask_d;
      pc_q      <= pc_d;
      pc_load_q <= pc_load_d;
      file_q    <= file_d;
    end
  end

  // ****************************************************************
  // wake pin synchroniser
  // ****************************************************************
  // third stage feeds only the edge detector, never the first stage
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
      wake_s3_q <= 1'b0;
    end else begin
      wake_s1_q <= i_wake_pin;
      wake_s2_q <= wake_s1_q;
      wake_s3_q <= wake_s2_q;
    end
  end

  // ****************************************************************
  // interrupt status, sticky
  // ****************************************************************
  // set wins over a write-one clear in the same cycle
  always_comb begin
    ist_d = ist_q;
    if (i_wr && (i_addr == exec_subset_pkg::REG_IRQ_STAT)) begin
      ist_d = ist_q & ~i_wdata[exec_subset_pkg::IRQ_W-1:0];
    end
    ist_d = ist_d | ev;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ist_q <= '0;
    end else begin
      ist_q <= ist_d;
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (i_rd) begin
      if (bus_fidx[5]) begin
        rdata_d[7:0] = file_q[bus_fidx[4:0]];
      end
      case (i_addr)
        exec_subset_pkg::REG_ACC:      rdata_d[7:0] = acc_q;
        exec_subset_pkg::REG_OPTION:   rdata_d[7:0] = option_q;
        exec_subset_pkg::REG_FLAGS: begin
          rdata_d[exec_subset_pkg::FLG_CARRY] = flags_q.carry;
          rdata_d[exec_subset_pkg::FLG_HALF]  = flags_q.half;
          rdata_d[exec_subset_pkg::FLG_ZERO]  = flags_q.zero;
          rdata_d[exec_subset_pkg::FLG_PDOWN] = pdown_q;
          rdata_d[exec_subset_pkg::FLG_TO]    = to_q;
          rdata_d[exec_subset_pkg::FLG_WUF]   = wuf_q;
        end
        exec_subset_pkg::REG_WDOG:     rdata_d[15:0] = {8'(wpre_q), 8'(wcnt_q)};
        exec_subset_pkg::REG_IRQ_STAT: rdata_d[exec_subset_pkg::IRQ_W-1:0] = ist_q;
        exec_subset_pkg::REG_IRQ_MASK: rdata_d[exec_subset_pkg::IRQ_W-1:0] = imask_q;
        exec_subset_pkg::REG_STATE:    rdata_d[1:0] = state_q;
        default: ;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_rdata    = rdata_q;
  assign o_option   = option_q;
  assign o_pc_value = pc_q;
  assign o_pc_load  = pc_load_q;
  assign o_refetch  = (state_q == ST_REFETCH);
  assign o_osc_stop = (state_q == ST_SLEEP);
  assign o_irq      = |(ist_q & imask_q);

endmodule : instruction_exec_subset

// ==== core/exec_subset_pkg.sv ====
package exec_subset_pkg;

  // ****************************************************************
  // instruction encodings (12-bit instruction word)
  // ****************************************************************
  localparam int          INSTR_W        = 12;
  localparam logic [11:0] OPC_OPTION     = 12'h002;
  localparam logic [11:0] OPC_SLEEP      = 12'h003;
  localparam logic [11:0] MSK_LIT        = 12'hf00;
  localparam logic [11:0] OPC_RET_LIT    = 12'h800;
  localparam logic [11:0] MSK_FILE_OP    = 12'hfc0;
  localparam logic [11:0] OPC_SUB_FILE   = 12'h080;
  localparam logic [11:0] OPC_ROT_RIGHT  = 12'h300;
  localparam logic [11:0] OPC_ROT_LEFT   = 12'h340;
  localparam int          DEST_BIT       = 5;
  localparam int          FILE_ADDR_W    = 5;
  localparam int          FILE_DEPTH     = 32;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_ACC        = 8'h04;
  localparam logic [7:0]  REG_OPTION     = 8'h08;
  localparam logic [7:0]  REG_FLAGS      = 8'h0c;
  localparam logic [7:0]  REG_WDOG       = 8'h10;
  localparam logic [7:0]  REG_IRQ_STAT   = 8'h14;
  localparam logic [7:0]  REG_IRQ_MASK   = 8'h18;
  localparam logic [7:0]  REG_STATE      = 8'h1c;
  localparam logic [7:0]  FILE_BASE      = 8'h80;

  // ctrl and flag field positions
  localparam int          CTRL_WAKE_BIT  = 0;
  localparam int          FLG_CARRY      = 0;
  localparam int          FLG_HALF       = 1;
  localparam int          FLG_ZERO       = 2;
  localparam int          FLG_PDOWN      = 3;
  localparam int          FLG_TO         = 4;
  localparam int          FLG_WUF        = 5;

  // interrupt status bits
  localparam int          IRQ_W          = 5;
  localparam int          EV_OPTION      = 0;
  localparam int          EV_RETURN      = 1;
  localparam int          EV_SLEEP       = 2;
  localparam int          EV_WAKE        = 3;
  localparam int          EV_UNKNOWN     = 4;

  // reset values
  localparam logic [7:0]  OPTION_RST     = 8'hff;
  localparam logic        TO_RST         = 1'b1;
  localparam logic        PDOWN_RST      = 1'b1;

  // watchdog widths
  localparam int          WDOG_PRE_W     = 8;
  localparam int          WDOG_CNT_W     = 8;

  typedef enum logic [2:0] {
    OP_NONE, OP_OPTION, OP_SLEEP, OP_RET_LIT, OP_SUB, OP_ROT_L, OP_ROT_R, OP_UNKNOWN
  } op_t;

  typedef struct packed {
    logic carry;
    logic half;
    logic zero;
  } alu_flags_t;

  typedef struct packed {
    logic [7:0] result;
    alu_flags_t flags;
    logic       wr_carry;
    logic       wr_half;
    logic       wr_zero;
  } alu_res_t;

endpackage : exec_subset_pkg

// ==== core/exec_alu.sv ====
`timescale 1ns/1ns
module exec_alu (
  input  wire exec_subset_pkg::op_t       i_op,
  input  wire logic [7:0]                 i_file,
  input  wire logic [7:0]                 i_acc,
  input  wire logic                       i_carry,
  output exec_subset_pkg::alu_res_t       o_res
);

  // ****************************************************************
  // arithmetic and rotate datapath
  // ****************************************************************
  logic [8:0] diff;
  logic [4:0] low_diff;

  // subtract as f + ~w + 1, so carry means no borrow
  assign diff     = {1'b0, i_file} + {1'b0, ~i_acc} + 9'h001;
  assign low_diff = {1'b0, i_file[3:0]} + {1'b0, ~i_acc[3:0]} + 5'h01;

  always_comb begin
    o_res = '0;
    case (i_op)
      exec_subset_pkg::OP_SUB: begin
        o_res.result      = diff[7:0];
        o_res.flags.carry = diff[8];
        o_res.flags.half  = low_diff[4];
        o_res.flags.zero  = (diff[7:0] == 8'h00);
        o_res.wr_carry    = 1'b1;
        o_res.wr_half     = 1'b1;
        o_res.wr_zero     = 1'b1;
      end
      exec_subset_pkg::OP_ROT_L: begin
        o_res.result      = {i_file[6:0], i_carry};
        o_res.flags.carry = i_file[7];
        o_res.wr_carry    = 1'b1;
      end
      exec_subset_pkg::OP_ROT_R: begin
        o_res.result      = {i_carry, i_file[7:1]};
        o_res.flags.carry = i_file[0];
        o_res.wr_carry    = 1'b1;
      end
      default: begin
        o_res = '0;
      end
    endcase
  end

endmodule : exec_alu

// ==== test/instruction_exec_subset_props.sv ====
`timescale 1ns/1ns
module instruction_exec_subset_props #(
  parameter int PC_W = 10
) (
  input wire logic            i_sys_clk,
  input wire logic            i_arst_n,
  input wire logic            i_instr_valid,
  input wire logic [11:0]     i_instr,
  input wire logic            o_instr_ready,
  input wire logic [PC_W-1:0] i_stack_top,
  input wire logic            o_pc_load,
  input wire logic [PC_W-1:0] o_pc_value,
  input wire logic            o_refetch,
  input wire logic [7:0]      o_option,
  input wire logic            o_osc_stop,
  input wire logic [7:0]      i_addr,
  input wire logic            i_wr
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  // ****************************************************************
  // decode of what the core takes this edge
  // ****************************************************************
  wire logic take     = i_instr_valid && o_instr_ready;
  wire logic ret_take = take &&
    ((i_instr & exec_subset_pkg::MSK_LIT) == exec_subset_pkg::OPC_RET_LIT);
  wire logic opt_take = take && (i_instr == exec_subset_pkg::OPC_OPTION);
  wire logic slp_take = take && (i_instr == exec_subset_pkg::OPC_SLEEP);
  wire logic opt_wr   = i_wr && (i_addr == exec_subset_pkg::REG_OPTION);

  // ****************************************************************
  // assertions
  // ****************************************************************
  ret_pc_a: assert property (ret_take |=> o_pc_load && o_pc_value == $past(i_stack_top))
    else $error("return address not loaded");
  ret_gap_a: assert property (ret_take |=> !o_instr_ready ##1 o_instr_ready)
    else $error("literal return not two cycles");
  refetch_src_a: assert property ($rose(o_refetch) |-> $past(ret_take))
    else $error("refetch without literal return");
  pc_pulse_a: assert property (o_pc_load |=> !o_pc_load)
    else $error("pc load longer than one cycle");
  pc_hold_a: assert property (!o_pc_load |-> $stable(o_pc_value))
    else $error("pc value moved without load");
  option_src_a: assert property ($changed(o_option) |-> $past(opt_take || opt_wr))
    else $error("option changed without cause");
  sleep_stop_a: assert property (slp_take |=> o_osc_stop && !o_instr_ready)
    else $error("sleep did not stop the core");
  stop_block_a: assert property (o_osc_stop |-> !o_instr_ready && !o_pc_load)
    else $error("core active while stopped");

  // main scenarios reached
  ret_c: cover property (ret_take);
  slp_c: cover property (slp_take ##1 o_osc_stop);
  opt_c: cover property (opt_take);
endmodule : instruction_exec_subset_props

bind instruction_exec_subset instruction_exec_subset_props #(.PC_W(PC_W)) props_i (
  .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_instr_valid(i_instr_valid),
  .i_instr(i_instr), .o_instr_ready(o_instr_ready), .i_stack_top(i_stack_top),
  .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_refetch(o_refetch),
  .o_option(o_option), .o_osc_stop(o_osc_stop), .i_addr(i_addr), .i_wr(i_wr)
);

// ==== test/instruction_exec_subset_tb.sv ====
`timescale 1ns/1ns
module instruction_exec_subset_tb;
  logic        i_sys_clk;
  logic        i_arst_n;
  logic        i_instr_valid;
  logic        o_instr_ready;
  logic [11:0] i_instr;
  logic [9:0]  i_stack_top;
  logic [9:0]  o_pc_value;
  logic        o_pc_load;
  logic        o_refetch;
  logic [7:0]  o_option;
  logic        o_osc_stop;
  logic        i_wake_pin;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        o_irq;
  int          fails;
  int          comparisons;

  instruction_exec_subset #(.PC_W(10)) instruction_exec_subset_i (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .o_instr_ready(o_instr_ready), .i_stack_top(i_stack_top),
    .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_refetch(o_refetch),
    .o_option(o_option), .o_osc_stop(o_osc_stop), .i_wake_pin(i_wake_pin),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_irq(o_irq)
  );

  // 25 MHz core clock
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
    #1;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    #1;
    if (what != "") begin
      check(what, exp, o_rdata);
    end
  endtask : rd_reg

  // bounded wait; a hang ends the run as a mismatch
  task automatic wait_ready();
    int n;
    n = 0;
    while (o_instr_ready !== 1'b1 && n < 50) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    if (n == 50) begin
      fails++;
      give_verdict();
    end
  endtask : wait_ready

  // returns in the cycle after the instruction was taken
  task automatic exec(input logic [11:0] ins, input logic [9:0] top);
    wait_ready();
    @(posedge i_sys_clk);
    i_instr_valid <= 1'b1;
    i_instr       <= ins;
    i_stack_top   <= top;
    @(posedge i_sys_clk);
    i_instr_valid <= 1'b0;
    #1;
  endtask : exec

  task automatic file_op(input logic [11:0] base, input logic [4:0] f, input logic d,
                         input logic [7:0] fv, input logic [7:0] av, input logic [2:0] fl);
    logic [7:0] res;
    logic [2:0] nf;
    wr_reg(exec_subset_pkg::REG_ACC, {24'h0, av});
    wr_reg(exec_subset_pkg::FILE_BASE + {1'b0, f, 2'b00}, {24'h0, fv});
    wr_reg(exec_subset_pkg::REG_FLAGS, {29'h0, fl});
    exec(base | {6'h0, d, f}, 10'h000);
    nf = fl;
    if (base == exec_subset_pkg::OPC_ROT_LEFT) begin
      res   = {fv[6:0], fl[0]};
      nf[0] = fv[7];
    end else if (base == exec_subset_pkg::OPC_ROT_RIGHT) begin
      res   = {fl[0], fv[7:1]};
      nf[0] = fv[0];
    end else begin
      res = fv - av;
      nf  = {res == 8'h00, fv[3:0] >= av[3:0], fv >= av};
    end
    rd_reg(exec_subset_pkg::REG_ACC, {24'h0, d ? av : res}, "acc");
    rd_reg(exec_subset_pkg::FILE_BASE + {1'b0, f, 2'b00}, {24'h0, d ? res : fv}, "file");
    rd_reg(exec_subset_pkg::REG_FLAGS, {29'h3, nf}, "flags");
  endtask : file_op

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    fails = 0;
    comparisons = 0;
    i_arst_n = 1'b0;
    i_instr_valid = 1'b0;
    i_instr = 12'h000;
    i_stack_top = 10'h000;
    i_wake_pin = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (20) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    rd_reg(exec_subset_pkg::REG_OPTION, 32'hff, "option reset");
    wr_reg(exec_subset_pkg::REG_ACC, 32'h5a);
    wr_reg(exec_subset_pkg::REG_FLAGS, 32'h7);
    exec(exec_subset_pkg::OPC_OPTION, 10'h000);
    check("option", 32'h5a, {24'h0, o_option});
    rd_reg(exec_subset_pkg::REG_FLAGS, 32'h1f, "flags");
    // both literal boundaries, each from its own return address
    for (int k = 0; k < 2; k++) begin
      exec(exec_subset_pkg::OPC_RET_LIT | (k ? 12'h0ff : 12'h000), k ? 10'h3a5 : 10'h05a);
      check("pc load", 32'h1, {31'h0, o_pc_load});
      check("pc value", k ? 32'h3a5 : 32'h05a, {22'h0, o_pc_value});
      check("refetch", 32'h2, {30'h0, o_refetch, o_instr_ready});
      rd_reg(exec_subset_pkg::REG_ACC, k ? 32'hff : 32'h0, "acc");
      rd_reg(exec_subset_pkg::REG_FLAGS, 32'h1f, "flags");
    end
    exec(12'hfff, 10'h000);
    rd_reg(exec_subset_pkg::REG_IRQ_STAT, 32'h13, "irq status");
    rd_reg(8'h40, 32'h0, "unmapped");
    file_op(exec_subset_pkg::OPC_SUB_FILE, 5'd31, 1'b0, 8'h05, 8'h06, 3'h7);
    file_op(exec_subset_pkg::OPC_SUB_FILE, 5'd0, 1'b1, 8'h3c, 8'h3c, 3'h0);
    file_op(exec_subset_pkg::OPC_SUB_FILE, 5'd7, 1'b1, 8'h10, 8'h01, 3'h0);
    file_op(exec_subset_pkg::OPC_ROT_LEFT, 5'd31, 1'b1, 8'h81, 8'h33, 3'h6);
    file_op(exec_subset_pkg::OPC_ROT_LEFT, 5'd3, 1'b0, 8'h40, 8'h33, 3'h1);
    file_op(exec_subset_pkg::OPC_ROT_RIGHT, 5'd0, 1'b0, 8'h01, 8'h33, 3'h7);
    file_op(exec_subset_pkg::OPC_ROT_RIGHT, 5'd16, 1'b1, 8'h80, 8'h33, 3'h0);
    // sleep, then wake by the pin
    wr_reg(exec_subset_pkg::REG_IRQ_STAT, 32'h1f);
    wr_reg(exec_subset_pkg::REG_FLAGS, 32'h0);
    exec(exec_subset_pkg::OPC_SLEEP, 10'h000);
    check("stopped", 32'h2, {30'h0, o_osc_stop, o_instr_ready});
    rd_reg(exec_subset_pkg::REG_WDOG, 32'h0, "");
    check("wdog", 32'h1, {31'h0, o_rdata[7:0] == 8'h00 && o_rdata[15:8] < 8'h08});
    rd_reg(exec_subset_pkg::REG_FLAGS, 32'h10, "flags");
    rd_reg(exec_subset_pkg::REG_STATE, 32'h2, "state");
    wr_reg(exec_subset_pkg::REG_IRQ_MASK, 32'h4);
    check("irq", 32'h1, {31'h0, o_irq});
    wr_reg(exec_subset_pkg::REG_IRQ_STAT, 32'h4);
    check("irq", 32'h0, {31'h0, o_irq});
    wr_reg(exec_subset_pkg::REG_IRQ_MASK, 32'h0);
    @(posedge i_sys_clk);
    i_wake_pin <= 1'b1;
    wait_ready();
    rd_reg(exec_subset_pkg::REG_FLAGS, 32'h30, "flags after wake");
    rd_reg(exec_subset_pkg::REG_IRQ_STAT, 32'h8, "wake event");
    // second sleep keeps the wake flag; control write wakes
    exec(exec_subset_pkg::OPC_SLEEP, 10'h000);
    rd_reg(exec_subset_pkg::REG_FLAGS, 32'h30, "flags");
    wr_reg(exec_subset_pkg::REG_CTRL, 32'h1);
    wait_ready();
    check("running", 32'h0, {31'h0, o_osc_stop});
    give_verdict();
  end
endmodule : instruction_exec_subset_tb
